// [verification/test_timer8_waveform_output_unit.sv]
// Purpose: self-checking bench for the timer waveform unit over APB
// Assumes: APB slave answers when it likes, TICK held high by the bench for n cycles in a row
// Notes: drivers change signals by non-blocking assignment at a rising edge
`timescale 1ns/1ps
`default_nettype none
`include "tw8_consts.svh"
module test_timer8_waveform_output_unit;
  import tw8_pkg::*;
  logic CLK, RST_N, TICK, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rq;
  logic [2:0] INT_ACK;
  logic PIN_A_O, PIN_A_OE, PIN_B_O, PIN_B_OE, OVF_FLAG, CMPA_FLAG, CMPB_FLAG, re;
  logic [1:0] req_val, req_dir, port_val, dir, pin_level;
  tw8_pin_s pin_a, pin_b;
  integer bad_count = 0;
  integer n_checks = 0;
  integer cycles = 0;
  assign pin_a = {PIN_A_O, PIN_A_OE};
  assign pin_b = {PIN_B_O, PIN_B_OE};
  tw8_waveform_unit u_tw8_waveform_unit (.CLK(CLK), .RST_N(RST_N), .TICK(TICK),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .INT_ACK(INT_ACK),
    .PORT_VAL_A(port_val[0]), .PORT_VAL_B(port_val[1]), .PIN_DIR_A(dir[0]),
    .PIN_DIR_B(dir[1]), .PIN_A_O(PIN_A_O), .PIN_A_OE(PIN_A_OE), .PIN_B_O(PIN_B_O),
    .PIN_B_OE(PIN_B_OE), .OVF_FLAG(OVF_FLAG), .CMPA_FLAG(CMPA_FLAG),
    .CMPB_FLAG(CMPB_FLAG));
  tw8_port_model u_tw8_port_model (.clk(CLK), .req_val(req_val), .req_dir(req_dir),
    .pin_a(pin_a), .pin_b(pin_b), .port_val(port_val), .dir(dir),
    .pin_level(pin_level));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  task results;
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // cut a hang short well above the expected run of about 400 cycles
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count = bad_count + 1;
      results;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // values read right after the edge are those settled before it
  task cyc;
    @(posedge CLK);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks = n_checks + 1;
    if (g !== x) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // one APB transfer; result lands in rq and re
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer i;
    i = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    cyc;
    PENABLE <= 1'b1;
    cyc;
    i = i + 1;
    while (PREADY !== 1'b1 && i < 20) begin
      cyc;
      i = i + 1;
    end
    if (PREADY !== 1'b1) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: no ready", $time);
    end
    rq = PRDATA;
    re = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    cyc;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  task tick(input integer n);
    repeat (n) begin
      TICK <= 1'b1;
      cyc;
    end
    TICK <= 1'b0;
    // second edge lets the pin register catch up with the state
    cyc;
    cyc;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {RST_N, TICK, PSEL, PENABLE, PWRITE} = 5'h00;
    PADDR = 8'h00;
    PWDATA = 32'h00000000;
    INT_ACK = 3'h0;
    req_val = 2'h0;
    req_dir = 2'h0;
    repeat (6) cyc;
    RST_N <= 1'b1;
    cyc;
    chk({PIN_A_O, PIN_B_O, OVF_FLAG, CMPA_FLAG, CMPB_FLAG}, 32'h0);
    rd(`TW8_OFS_STAT);
    chk(rq, 32'h0);
    rd(8'h1C);
    chk(re, 32'h1);
    // normal mode wrap and sticky overflow
    wr(`TW8_OFS_CTRL, 8'h00);
    wr(`TW8_OFS_COUNT, 8'hFE);
    tick(1);
    chk(OVF_FLAG, 32'h0);
    tick(1);
    chk(OVF_FLAG, 32'h1);
    rd(`TW8_OFS_COUNT);
    chk(rq, 32'h0);
    tick(1);
    chk(OVF_FLAG, 32'h1);
    wr(`TW8_OFS_FLAGS, 8'h07);
    chk(OVF_FLAG, 32'h0);
    wr(`TW8_OFS_CMPB, 8'h03);
    tick(2);
    chk(CMPB_FLAG, 32'h0);
    tick(1);
    chk(CMPB_FLAG, 32'h1);
    INT_ACK <= 3'h6;
    cyc;
    INT_ACK <= 3'h0;
    cyc;
    chk(CMPB_FLAG, 32'h0);
    // force a set in normal mode; direction still gates the pin
    req_val <= 2'h0;
    wr(`TW8_OFS_CTRL, 8'h18);
    wr(`TW8_OFS_FORCE, 8'h01);
    cyc;
    chk({PIN_A_O, PIN_A_OE, pin_level[0], CMPA_FLAG}, 32'hA);
    req_dir <= 2'h1;
    repeat (3) cyc;
    chk({PIN_A_O, PIN_A_OE, pin_level[0]}, 32'h7);
    wr(`TW8_OFS_CTRL, 8'h00);
    cyc;
    chk(PIN_A_O, 32'h0);
    // clear-on-compare with toggle, port value opposite to the state
    req_val <= 2'h1;
    wr(`TW8_OFS_CMPA, 8'h02);
    wr(`TW8_OFS_CTRL, 8'h0A);
    wr(`TW8_OFS_COUNT, 8'h00);
    wr(`TW8_OFS_FLAGS, 8'h07);
    tick(3);
    chk(CMPA_FLAG, 32'h1);
    chk(PIN_A_O, 32'h0);
    rd(`TW8_OFS_COUNT);
    chk(rq, 32'h0);
    tick(3);
    chk(PIN_A_O, 32'h1);
    // compare written below count: run through 0xFF first
    wr(`TW8_OFS_COUNT, 8'h05);
    wr(`TW8_OFS_FLAGS, 8'h07);
    tick(250);
    chk({OVF_FLAG, CMPA_FLAG}, 32'h0);
    tick(1);
    chk(OVF_FLAG, 32'h1);
    tick(3);
    chk(CMPA_FLAG, 32'h1);
    // output mode zero leaves the state alone at a match
    wr(`TW8_OFS_CTRL, 8'h02);
    tick(3);
    rd(`TW8_OFS_STAT);
    chk(rq[0], 32'h0);
    // fast PWM to 0xFF, non-inverting, buffered compare
    wr(`TW8_OFS_CTRL, 8'h13);
    wr(`TW8_OFS_CMPA, 8'h10);
    wr(`TW8_OFS_FORCE, 8'h01);
    wr(`TW8_OFS_COUNT, 8'hFE);
    wr(`TW8_OFS_FLAGS, 8'h07);
    tick(1);
    rd(`TW8_OFS_STAT);
    chk(rq[0], 32'h0);
    tick(1);
    chk(OVF_FLAG, 32'h1);
    rd(`TW8_OFS_COUNT);
    chk(rq, 32'h0);
    tick(16);
    chk(PIN_A_O, 32'h1);
    tick(1);
    chk(PIN_A_O, 32'h0);
    results;
  end
endmodule
`default_nettype wire

// [verification/tw8_port_model.sv]
// Purpose: general port pin and direction logic beside the waveform unit
// Assumes: bench requests port value and direction; pin has a pull-up
// Notes: pin level resolves from the unit's enable, not from the last driven value
`timescale 1ns/1ps
`default_nettype none
module tw8_port_model
  import tw8_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] req_val,
  input wire logic [1:0] req_dir,
  input wire tw8_pin_s pin_a,
  input wire tw8_pin_s pin_b,
  output logic [1:0] port_val,
  output logic [1:0] dir,
  output logic [1:0] pin_level
);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    port_val <= req_val;
    dir <= req_dir;
  end
  ////////////////////////////////////////////////////////////////////////////
  // released pin floats to the pull-up level
  assign pin_level[0] = pin_a.oe ? pin_a.o : 1'b1;
  assign pin_level[1] = pin_b.oe ? pin_b.o : 1'b1;
endmodule
`default_nettype wire

// [verilog/tw8_consts.svh]
// Purpose: offsets, field positions, reset values and codes of the waveform unit
// Assumes: included by its bare name
// Notes: definitions only
`ifndef TW8_CONSTS_SVH
`define TW8_CONSTS_SVH

`define TW8_OFS_CTRL 8'h00
`define TW8_OFS_COUNT 8'h04
`define TW8_OFS_CMPA 8'h08
`define TW8_OFS_CMPB 8'h0C
`define TW8_OFS_FLAGS 8'h10
`define TW8_OFS_FORCE 8'h14
`define TW8_OFS_STAT 8'h18

`define TW8_CTRL_WIDTH 7
`define TW8_FLAG_OVF 0
`define TW8_FLAG_CMPA 1
`define TW8_FLAG_CMPB 2
`define TW8_STAT_BLOCK 2

`define TW8_CTRL_RST 7'h00
`define TW8_COUNT_RST 8'h00
`define TW8_CMP_RST 8'h00
`define TW8_FLAGS_RST 3'h0
`define TW8_STATE_RST 2'h0

`define TW8_BOTTOM 8'h00
`define TW8_MAX 8'hFF

`define TW8_WAVE_NORMAL 3'h0
`define TW8_WAVE_CTC 3'h2
`define TW8_WAVE_FAST_MAX 3'h3
`define TW8_WAVE_FAST_CMPA 3'h7

`define TW8_COM_OFF 2'h0
`define TW8_COM_TOGGLE 2'h1
`define TW8_COM_CLEAR 2'h2
`define TW8_COM_SET 2'h3

`endif

// [verilog/tw8_pkg.sv]
// Purpose: types shared by the waveform unit
// Assumes: nothing
// Notes: control layout matches the low bits of the control register
package tw8_pkg;

  typedef struct packed {
    logic [1:0] cmp_out_mode_b;
    logic [1:0] cmp_out_mode_a;
    logic [2:0] wave_mode_sel;
  } tw8_ctrl_s;

  typedef struct packed {
    logic o;
    logic oe;
  } tw8_pin_s;

endpackage

// [verilog/tw8_waveform_unit.sv]
// Purpose: 8-bit timer counting sequence, compare outputs and pin override
// Assumes: APB3 slave, TICK is the one-cycle timer clock enable
// Notes: all state on CLK, synchronous active-low reset
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tw8_consts.svh"

module tw8_waveform_unit
  import tw8_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic TICK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [2:0] INT_ACK,
  input wire logic PORT_VAL_A,
  input wire logic PORT_VAL_B,
  input wire logic PIN_DIR_A,
  input wire logic PIN_DIR_B,
  output logic PIN_A_O,
  output logic PIN_A_OE,
  output logic PIN_B_O,
  output logic PIN_B_OE,
  output logic OVF_FLAG,
  output logic CMPA_FLAG,
  output logic CMPB_FLAG
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  tw8_ctrl_s ctrl_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] cmp_buf_reg [2];
  logic [7:0] cmp_act_reg [2];
  logic [2:0] flag_reg;
  logic [2:0] flag_next;
  logic [1:0] state_reg;
  logic [1:0] state_next;
  logic block_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  tw8_pin_s pin_a_reg;
  tw8_pin_s pin_b_reg;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic act_on_match(input logic [1:0] com, input logic s,
                                        input logic tog_ok);
    logic r;
    r = s;
    case (com)
      `TW8_COM_TOGGLE: r = tog_ok ? ~s : s;
      `TW8_COM_CLEAR: r = 1'b0;
      `TW8_COM_SET: r = 1'b1;
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic r;
    r = 1'b0;
    case (a)
      `TW8_OFS_CTRL, `TW8_OFS_COUNT, `TW8_OFS_CMPA, `TW8_OFS_CMPB,
      `TW8_OFS_FLAGS, `TW8_OFS_FORCE, `TW8_OFS_STAT: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic setup;
  logic wr;
  logic ctrl_wr;
  logic cnt_wr;
  logic flags_wr;
  logic force_wr;
  logic [1:0] cmp_wr;
  logic [31:0] rdata;

  assign setup = PSEL && !PENABLE;
  // a write lands only at the edge where the access phase meets ready
  assign wr = PSEL && PENABLE && pready_reg && PWRITE && !pslverr_reg;
  assign ctrl_wr = wr && (PADDR == `TW8_OFS_CTRL);
  assign cnt_wr = wr && (PADDR == `TW8_OFS_COUNT);
  assign cmp_wr[0] = wr && (PADDR == `TW8_OFS_CMPA);
  assign cmp_wr[1] = wr && (PADDR == `TW8_OFS_CMPB);
  assign flags_wr = wr && (PADDR == `TW8_OFS_FLAGS);
  assign force_wr = wr && (PADDR == `TW8_OFS_FORCE);

  always_comb begin
    rdata = 32'h0000_0000;
    case (PADDR)
      `TW8_OFS_CTRL: rdata[`TW8_CTRL_WIDTH-1:0] = ctrl_reg;
      `TW8_OFS_COUNT: rdata[7:0] = count_reg;
      `TW8_OFS_CMPA: rdata[7:0] = cmp_buf_reg[0];
      `TW8_OFS_CMPB: rdata[7:0] = cmp_buf_reg[1];
      `TW8_OFS_FLAGS: rdata[2:0] = flag_reg;
      `TW8_OFS_STAT: rdata[2:0] = {block_reg, state_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ready is raised for the access phase after every setup cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !is_mapped(PADDR);
      prdata_reg <= PWRITE ? 32'h0000_0000 : rdata;
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg <= `TW8_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= PWDATA[`TW8_CTRL_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  logic [2:0] wmode;
  logic pwm;
  logic clear_on_compare_mode;
  logic [7:0] top;
  logic at_top;
  logic [1:0] match;
  logic [1:0] force_s;

  assign wmode = ctrl_reg.wave_mode_sel;
  // unlisted codes fall back to normal counting with non-PWM actions
  assign pwm = (wmode == `TW8_WAVE_FAST_MAX) || (wmode == `TW8_WAVE_FAST_CMPA);
  assign clear_on_compare_mode = (wmode == `TW8_WAVE_CTC);
  assign top = (wmode == `TW8_WAVE_FAST_CMPA) ? cmp_act_reg[0] : `TW8_MAX;
  assign at_top = (count_reg == top);
  // a counter write masks the next tick's matches
  assign match[0] = (count_reg == cmp_act_reg[0]) && !block_reg;
  assign match[1] = (count_reg == cmp_act_reg[1]) && !block_reg;
  assign force_s = force_wr && !pwm ? PWDATA[1:0] : 2'b00;

  ////////////////////////////////////////////////////////////////////////////
  // counter: the sequence looks at the wave mode only

  always_comb begin
    count_next = count_reg;
    if (cnt_wr) begin
      count_next = PWDATA[7:0];
    end else if (TICK) begin
      case (wmode)
        `TW8_WAVE_CTC: begin
          // equality with the live compare A, so a low write runs to wrap
          count_next = (count_reg == cmp_act_reg[0]) ? `TW8_BOTTOM : count_reg + 8'h01;
        end
        `TW8_WAVE_FAST_MAX, `TW8_WAVE_FAST_CMPA: begin
          count_next = at_top ? `TW8_BOTTOM : count_reg + 8'h01;
        end
        default: begin
          count_next = count_reg + 8'h01;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      count_reg <= `TW8_COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;
    end else if (TICK) begin
      block_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare registers: buffered in PWM, transparent otherwise

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmp_buf_reg[0] <= `TW8_CMP_RST;
      cmp_buf_reg[1] <= `TW8_CMP_RST;
      cmp_act_reg[0] <= `TW8_CMP_RST;
      cmp_act_reg[1] <= `TW8_CMP_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cmp_wr[i]) begin
          cmp_buf_reg[i] <= PWDATA[7:0];
        end
        if (!pwm) begin
          cmp_act_reg[i] <= cmp_wr[i] ? PWDATA[7:0] : cmp_buf_reg[i];
        end else if (TICK && at_top) begin
          cmp_act_reg[i] <= cmp_buf_reg[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: a set in the same cycle as a clear wins

  always_comb begin
    flag_next = flag_reg;
    if (flags_wr) begin
      flag_next = flag_next & ~PWDATA[2:0];
    end
    flag_next = flag_next & ~INT_ACK;
    if (TICK) begin
      // normal and clear modes flag the wrap, fast PWM flags top
      if (pwm ? at_top : (count_reg == `TW8_MAX)) begin
        flag_next[`TW8_FLAG_OVF] = 1'b1;
      end
      if (match[0]) begin
        flag_next[`TW8_FLAG_CMPA] = 1'b1;
      end
      if (match[1]) begin
        flag_next[`TW8_FLAG_CMPB] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flag_reg <= `TW8_FLAGS_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare output states

  always_comb begin
    logic [1:0] com;
    logic tog_ok;
    com = 2'b00;
    tog_ok = 1'b0;
    state_next = state_reg;
    for (int i = 0; i < 2; i++) begin
      com = (i == 0) ? ctrl_reg.cmp_out_mode_a : ctrl_reg.cmp_out_mode_b;
      // only channel A may toggle in PWM, and only with the high mode bit
      tog_ok = !pwm || ((i == 0) && wmode[2]);
      if (TICK && pwm && at_top && com[1]) begin
        // bottom action; a match on top is ignored here
        state_next[i] = (com == `TW8_COM_CLEAR);
      end else if (TICK && match[i]) begin
        // the mode is read live, so a change acts at the next match
        state_next[i] = act_on_match(com, state_reg[i], tog_ok);
      end else if (force_s[i]) begin
        state_next[i] = act_on_match(com, state_reg[i], 1'b1);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg <= `TW8_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin override; a pin shows the state only while its direction is output

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_a_reg <= '0;
      pin_b_reg <= '0;
    end else begin
      pin_a_reg.o <= (ctrl_reg.cmp_out_mode_a != `TW8_COM_OFF) ? state_reg[0] : PORT_VAL_A;
      pin_b_reg.o <= (ctrl_reg.cmp_out_mode_b != `TW8_COM_OFF) ? state_reg[1] : PORT_VAL_B;
      pin_a_reg.oe <= PIN_DIR_A;
      pin_b_reg.oe <= PIN_DIR_B;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign PIN_A_O = pin_a_reg.o;
  assign PIN_A_OE = pin_a_reg.oe;
  assign PIN_B_O = pin_b_reg.o;
  assign PIN_B_OE = pin_b_reg.oe;
  assign OVF_FLAG = flag_reg[`TW8_FLAG_OVF];
  assign CMPA_FLAG = flag_reg[`TW8_FLAG_CMPA];
  assign CMPB_FLAG = flag_reg[`TW8_FLAG_CMPB];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_ctc_hit;
    TICK && clear_on_compare_mode && !cnt_wr && !block_reg && (count_reg == cmp_act_reg[0]);
  endsequence

  sequence s_fast_top;
    TICK && pwm && !cnt_wr && at_top;
  endsequence

  state_reset_a: assert property ($rose(RST_N) |-> state_reg == 2'b00)
    else $error("compare output state not cleared by reset");

  pin_override_a: assert property ((ctrl_reg.cmp_out_mode_a != 2'b00)
    |=> PIN_A_O == $past(state_reg[0]))
    else $error("pin A does not carry the compare output state");

  pin_dir_a: assert property (1'b1 |=> PIN_A_OE == $past(PIN_DIR_A))
    else $error("pin A enable does not follow its direction bit");

  mode_zero_hold_a: assert property (ctrl_reg.cmp_out_mode_a == 2'b00 && !ctrl_wr
    |=> $stable(state_reg[0]))
    else $error("channel A state moved with output mode zero");

  normal_wrap_a: assert property (TICK && wmode == 3'h0 && !cnt_wr && count_reg == 8'hFF
    |=> count_reg == 8'h00 && OVF_FLAG)
    else $error("normal mode wrap or overflow flag wrong");

  ctc_clear_a: assert property (s_ctc_hit |=> count_reg == 8'h00 && CMPA_FLAG)
    else $error("clear mode did not clear or flag at compare A");

  ctc_toggle_a: assert property (s_ctc_hit and (ctrl_reg.cmp_out_mode_a == 2'b01)
    |=> state_reg[0] != $past(state_reg[0]))
    else $error("clear mode toggle missing on channel A");

  fast_top_a: assert property (s_fast_top |=> count_reg == 8'h00 && OVF_FLAG)
    else $error("fast PWM did not restart or flag overflow at top");

  force_noflag_a: assert property (force_wr && PWDATA[0] && !pwm && !TICK
    && !CMPA_FLAG |=> !CMPA_FLAG && $stable(count_reg))
    else $error("force touched the flag or the counter");

  flag_clear_a: assert property (INT_ACK[1] && !TICK |=> !CMPA_FLAG)
    else $error("acknowledge did not clear compare A flag");

endmodule
`default_nettype wire
